// File: design/nvsram_host_pkg.sv
// constants and types for the host-side controller of a nonvolatile-shadow sram
package nvsram_host_pkg;
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int CLK_MHZ = 40;
   localparam int CLK_NS = 25;
   // access phase lengths in cycles (25 ns each, device needs 25..45 ns)
   // setup spans two cycles so the address stands a full cycle before select falls
   localparam logic [3:0] SETUP_CYC = 4'h0002;
   localparam logic [3:0] STROBE_CYC = 4'h0002;
   localparam logic [3:0] RECOVER_CYC = 4'h0001;
   localparam int POWERUP_LOAD_US = 550;
   localparam int SAVE_MS = 10;
   localparam int LOAD_US = 20;
   localparam int POWERUP_LOAD_CYC = POWERUP_LOAD_US * CLK_MHZ;
   localparam int SAVE_CYC = SAVE_MS * 1000 * CLK_MHZ;
   localparam int LOAD_CYC = LOAD_US * CLK_MHZ;
   localparam int WAIT_W = 20;
   localparam logic [ADDR_W-1:0] SEQ_ADDR [0:4] = '{11'h0000, 11'h0555, 11'h02AA, 11'h07FF, 11'h00F0};
   localparam logic [ADDR_W-1:0] SAVE_ADDR = 11'h070F;
   localparam logic [ADDR_W-1:0] LOAD_ADDR = 11'h070E;
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_SAVE, OP_LOAD} op_t;
   typedef struct packed {
      op_t op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } req_t;
   typedef struct packed {
      logic chipSelN;
      logic writeStrobeN;
      logic outputGateN;
      logic [ADDR_W-1:0] addr;
   } pins_t;
endpackage

// File: design/nvsram_save_load_sequencer.sv
// host controller: runs reads, writes and save/load command sequences on the sram pins
`timescale 1ns/1ps
module nvsram_save_load_sequencer #(
   parameter int POWERUP_WAIT = nvsram_host_pkg::POWERUP_LOAD_CYC,
   parameter int SAVE_WAIT = nvsram_host_pkg::SAVE_CYC,
   parameter int LOAD_WAIT = nvsram_host_pkg::LOAD_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // user request side
   input wire logic reqValid,
   input wire nvsram_host_pkg::req_t req,
   output logic reqReady,
   output logic rdValid,
   output logic [nvsram_host_pkg::DATA_W-1:0] rdData,
   // device pins
   output logic chipSelN,
   output logic writeStrobeN,
   output logic outputGateN,
   output logic [nvsram_host_pkg::ADDR_W-1:0] addressLines,
   input wire logic [nvsram_host_pkg::DATA_W-1:0] dataLinesIn,
   output logic [nvsram_host_pkg::DATA_W-1:0] dataLinesOut,
   output logic dataLinesOe
);
   typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_WAIT} state_t;
   state_t state_q, state_d;
   logic [3:0] phase_q, phase_d;
   logic [2:0] step_q, step_d;
   logic [nvsram_host_pkg::WAIT_W-1:0] wait_q, wait_d;
   nvsram_host_pkg::req_t cur_q, cur_d;
   nvsram_host_pkg::pins_t pins_q, pins_d;
   logic [nvsram_host_pkg::DATA_W-1:0] rdData_q, rdData_d, wdata_q, wdata_d;
   logic rdValid_q, rdValid_d, ready_q, ready_d, oe_q, oe_d;
   logic isCmd, lastStep;
   logic [nvsram_host_pkg::ADDR_W-1:0] stepAddr;

   assign isCmd = (cur_q.op == nvsram_host_pkg::OP_SAVE) || (cur_q.op == nvsram_host_pkg::OP_LOAD);
   assign lastStep = (step_q == 3'h5);
   always_comb begin
      if (step_q < 3'h5) begin
         stepAddr = nvsram_host_pkg::SEQ_ADDR[step_q];
      end else if (cur_q.op == nvsram_host_pkg::OP_SAVE) begin
         stepAddr = nvsram_host_pkg::SAVE_ADDR;
      end else begin
         stepAddr = nvsram_host_pkg::LOAD_ADDR;
      end
   end

   always_comb begin
      state_d = state_q;
      phase_d = phase_q;
      step_d = step_q;
      wait_d = wait_q;
      cur_d = cur_q;
      pins_d = pins_q;
      rdData_d = rdData_q;
      wdata_d = wdata_q;
      rdValid_d = 1'b0;
      ready_d = 1'b0;
      oe_d = oe_q;
      unique case (state_q)
         ST_BOOT: begin
            // device runs its own load after power-up; no access until it is done
            if (wait_q == nvsram_host_pkg::WAIT_W'(POWERUP_WAIT - 1)) begin
               state_d = ST_IDLE;
               ready_d = 1'b1;
               wait_d = '0;
            end else begin
               wait_d = wait_q + 1'b1;
            end
         end
         ST_IDLE: begin
            ready_d = 1'b1;
            if (reqValid && ready_q) begin
               ready_d = 1'b0;
               cur_d = req;
               step_d = 3'h0;
               phase_d = nvsram_host_pkg::SETUP_CYC;
               state_d = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // address settles with select and strobe high; strobe falls only together with select, and only for writes
            pins_d.addr = isCmd ? stepAddr : cur_q.addr;
            pins_d.writeStrobeN = 1'b1;
            wdata_d = cur_q.wdata;
            if (phase_q == 4'h1) begin
               state_d = ST_STROBE;
               phase_d = nvsram_host_pkg::STROBE_CYC;
               pins_d.chipSelN = 1'b0;
               if (cur_q.op == nvsram_host_pkg::OP_WRITE) begin
                  pins_d.writeStrobeN = 1'b0;
                  oe_d = 1'b1;
               end else begin
                  // command reads leave the output gate high; data is only sampled for plain reads
                  pins_d.outputGateN = isCmd;
               end
            end else begin
               phase_d = phase_q - 1'b1;
            end
         end
         ST_STROBE: begin
            if (phase_q == 4'h1) begin
               if (cur_q.op == nvsram_host_pkg::OP_READ) begin
                  rdData_d = dataLinesIn;
                  rdValid_d = 1'b1;
               end
               pins_d.chipSelN = 1'b1;
               pins_d.writeStrobeN = 1'b1;
               pins_d.outputGateN = 1'b1;
               state_d = ST_RECOVER;
               phase_d = nvsram_host_pkg::RECOVER_CYC;
            end else begin
               phase_d = phase_q - 1'b1;
            end
         end
         ST_RECOVER: begin
            oe_d = 1'b0;
            if (phase_q == 4'h1) begin
               if (isCmd && !lastStep) begin
                  // no other access may slip between command steps
                  step_d = step_q + 1'b1;
                  phase_d = nvsram_host_pkg::SETUP_CYC;
                  state_d = ST_SETUP;
               end else if (isCmd) begin
                  wait_d = '0;
                  state_d = ST_WAIT;
               end else begin
                  state_d = ST_IDLE;
                  ready_d = 1'b1;
               end
            end else begin
               phase_d = phase_q - 1'b1;
            end
         end
         ST_WAIT: begin
            if (wait_q == nvsram_host_pkg::WAIT_W'(((cur_q.op == nvsram_host_pkg::OP_SAVE) ? SAVE_WAIT : LOAD_WAIT) - 1)) begin
               state_d = ST_IDLE;
               ready_d = 1'b1;
               step_d = 3'h0;
            end else begin
               wait_d = wait_q + 1'b1;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_BOOT;
         phase_q <= 4'h0;
         step_q <= 3'h0;
         wait_q <= '0;
         cur_q <= '0;
         pins_q <= '{chipSelN: 1'b1, writeStrobeN: 1'b1, outputGateN: 1'b1, addr: '0};
         rdData_q <= '0;
         wdata_q <= '0;
         rdValid_q <= 1'b0;
         ready_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         step_q <= step_d;
         wait_q <= wait_d;
         cur_q <= cur_d;
         pins_q <= pins_d;
         rdData_q <= rdData_d;
         wdata_q <= wdata_d;
         rdValid_q <= rdValid_d;
         ready_q <= ready_d;
         oe_q <= oe_d;
      end
   end

   assign reqReady = ready_q;
   assign rdValid = rdValid_q;
   assign rdData = rdData_q;
   assign chipSelN = pins_q.chipSelN;
   assign writeStrobeN = pins_q.writeStrobeN;
   assign outputGateN = pins_q.outputGateN;
   assign addressLines = pins_q.addr;
   assign dataLinesOut = wdata_q;
   assign dataLinesOe = oe_q;

   // strobe never falls together with select unless write; never low at select fall for reads
   AST_READ_STROBE_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
      (!chipSelN && cur_q.op != nvsram_host_pkg::OP_WRITE) |-> writeStrobeN)
      else $error("write strobe low during a read");
   AST_CMD_STROBE_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
      isCmd && state_q != ST_BOOT |-> writeStrobeN)
      else $error("write strobe low during command sequence");
   AST_ADDR_STABLE: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(chipSelN) |-> $stable(addressLines))
      else $error("address changed as select fell");
   AST_SELECT_PULSES: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(chipSelN) |-> !chipSelN [*2] ##1 chipSelN)
      else $error("select pulse width wrong");
   AST_SAVE_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
      (!chipSelN && isCmd && lastStep && cur_q.op == nvsram_host_pkg::OP_SAVE) |-> addressLines == 11'h070F)
      else $error("save step six address wrong");
   AST_LOAD_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
      (!chipSelN && isCmd && lastStep && cur_q.op == nvsram_host_pkg::OP_LOAD) |-> addressLines == 11'h070E)
      else $error("load step six address wrong");
   AST_FIRST_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
      (!chipSelN && isCmd && step_q == 3'h0) |-> addressLines == 11'h0000)
      else $error("command does not start at zero");
   AST_NO_GAP: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_RECOVER && isCmd && !lastStep && phase_q == 4'h1) |=> state_q == ST_SETUP)
      else $error("command sequence interrupted");
   AST_WAIT_BUSY: assert property (@(posedge sys_clk) disable iff (rst)
      state_q == ST_WAIT |-> chipSelN && !reqReady)
      else $error("access during nonvolatile operation");
   AST_READ_DONE: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_STROBE && phase_q == 4'h1 && cur_q.op == nvsram_host_pkg::OP_READ) |=> rdValid)
      else $error("read data not returned");
   COV_READ: cover property (@(posedge sys_clk) disable iff (rst) rdValid);
   COV_WRITE: cover property (@(posedge sys_clk) disable iff (rst) !writeStrobeN);
   COV_SAVE: cover property (@(posedge sys_clk) disable iff (rst) state_q == ST_WAIT && cur_q.op == nvsram_host_pkg::OP_SAVE);
   COV_LOAD: cover property (@(posedge sys_clk) disable iff (rst) state_q == ST_WAIT && cur_q.op == nvsram_host_pkg::OP_LOAD);
endmodule // nvsram_save_load_sequencer

// File: dv/nvsram_device_model.sv
// behavioural model of the nonvolatile-shadow sram seen from its pins
`timescale 1ns/1ps
module nvsram_device_model #(
   parameter int SAVE_NS = 500,
   parameter int LOAD_NS = 200,
   parameter int POWERUP_NS = 400
) (
   // pins from the host
   input wire logic chipSelN,
   input wire logic writeStrobeN,
   input wire logic outputGateN,
   input wire logic [10:0] addressLines,
   input wire logic [7:0] dataFromHost,
   // data lines back to the host
   output logic [7:0] dataToHost,
   output logic driving,
   // operation counters
   output int saveCnt,
   output int loadCnt
);
   logic [7:0] mem [0:2047];
   logic [7:0] shadow [0:2047];
   logic [7:0] lastQ;
   int step = 0;
   bit busy = 1;
   bit wrPend = 0;
   wire cmdHiZ = step == 5 && (addressLines == nvsram_host_pkg::SAVE_ADDR || addressLines == nvsram_host_pkg::LOAD_ADDR);
   // strobe low at select releases the lines; command step six stays released
   assign driving = !chipSelN && !outputGateN && writeStrobeN && !wrPend && !busy && !cmdHiZ;
   assign dataToHost = driving ? mem[addressLines] : ~lastQ;
   always @* if (driving) lastQ = mem[addressLines];
   task automatic load_all;
      for (int i = 0; i < 2048; i++) mem[i] = '0;
      for (int i = 0; i < 2048; i++) mem[i] = shadow[i];
   endtask
   initial begin
      saveCnt = 0;
      loadCnt = 0;
      lastQ = '0;
      for (int i = 0; i < 2048; i++) shadow[i] = i[7:0] ^ 8'h5A;
      #(POWERUP_NS);
      load_all();
      step = 0;
      busy = 0;
   end
   always @(negedge writeStrobeN or negedge chipSelN) if (!chipSelN && !writeStrobeN) wrPend = 1;
   // the delays below block the process, so accesses during an operation are ignored
   always @(posedge chipSelN) begin
      if (busy) begin
         wrPend = 0;
      end else if (wrPend) begin
         mem[addressLines] = dataFromHost;
         wrPend = 0;
         step = 0;
      end else if (step == 5 && addressLines == nvsram_host_pkg::SAVE_ADDR) begin
         busy = 1;
         for (int i = 0; i < 2048; i++) shadow[i] = mem[i];
         saveCnt++;
         #(SAVE_NS);
         step = 0;
         busy = 0;
      end else if (step == 5 && addressLines == nvsram_host_pkg::LOAD_ADDR) begin
         busy = 1;
         load_all();
         loadCnt++;
         #(LOAD_NS);
         step = 0;
         busy = 0;
      end else if (step < 5 && addressLines == nvsram_host_pkg::SEQ_ADDR[step]) begin
         step++;
      end else begin
         step = (addressLines == nvsram_host_pkg::SEQ_ADDR[0]) ? 1 : 0;
      end
   end
endmodule // nvsram_device_model

// File: dv/nvsram_save_load_sequencer_tb_top.sv
// self-checking bench for the save/load sequencer against the sram model
`timescale 1ns/1ps
module nvsram_save_load_sequencer_tb_top;
   logic sys_clk = 0;
   logic rst = 1;
   logic reqValid = 0;
   nvsram_host_pkg::req_t req = '0;
   logic reqReady, rdValid, chipSelN, writeStrobeN, outputGateN, dataLinesOe, devDrive;
   logic [7:0] rdData, dataLinesOut, devData, rd;
   logic [10:0] addressLines;
   int saveCnt, loadCnt;
   int error_cnt = 0;
   int checks_done = 0;
   // host drive wins; otherwise the model supplies data or the complement of the last byte it drove
   wire logic [7:0] dataLinesIn = dataLinesOe ? dataLinesOut : devData;
   always #12.5 sys_clk = ~sys_clk;
   nvsram_save_load_sequencer #(.POWERUP_WAIT(20), .SAVE_WAIT(30), .LOAD_WAIT(10)) u_nvsram_save_load_sequencer (
      .sys_clk(sys_clk), .rst(rst), .reqValid(reqValid), .req(req), .reqReady(reqReady), .rdValid(rdValid),
      .rdData(rdData), .chipSelN(chipSelN), .writeStrobeN(writeStrobeN), .outputGateN(outputGateN),
      .addressLines(addressLines), .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));
   nvsram_device_model u_nvsram_device_model (.chipSelN(chipSelN), .writeStrobeN(writeStrobeN),
      .outputGateN(outputGateN), .addressLines(addressLines), .dataFromHost(dataLinesOut),
      .dataToHost(devData), .driving(devDrive), .saveCnt(saveCnt), .loadCnt(loadCnt));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic doReq(input nvsram_host_pkg::op_t op, input logic [10:0] a, input logic [7:0] wd);
      int n;
      n = 0;
      @(negedge sys_clk);
      reqValid = 1;
      req = '{op: op, addr: a, wdata: wd};
      while (reqReady !== 1'b1 && n < 100) begin @(negedge sys_clk); n++; end
      @(negedge sys_clk);
      reqValid = 0;
      // first select pulse of every request, command step one included
      while (chipSelN !== 1'b0 && n < 200) begin @(negedge sys_clk); n++; end
      check(writeStrobeN, (op == nvsram_host_pkg::OP_WRITE) ? 0 : 1);
      check({outputGateN, dataLinesOe},
         (op == nvsram_host_pkg::OP_READ) ? 2'b00 : ((op == nvsram_host_pkg::OP_WRITE) ? 2'b11 : 2'b10));
      check(devDrive, op == nvsram_host_pkg::OP_READ);
      while (op == nvsram_host_pkg::OP_READ && rdValid !== 1'b1 && n < 300) begin @(negedge sys_clk); n++; end
      if (op == nvsram_host_pkg::OP_READ) check(rdValid, 1);
      rd = rdData;
      while (reqReady !== 1'b1 && n < 2000) begin @(negedge sys_clk); n++; end
      check(reqReady, 1);
   endtask
   task automatic powerupTest;
      int n;
      n = 0;
      check({chipSelN, reqReady, dataLinesOe}, 3'b100);
      @(negedge sys_clk);
      rst = 0;
      while (reqReady !== 1'b1 && n < 100) begin @(negedge sys_clk); n++; end
      check(n, 20);
      doReq(nvsram_host_pkg::OP_READ, 11'h0123, 8'h00);
      check(rd, 8'h23 ^ 8'h5A);
   endtask
   task automatic rwTest;
      for (int i = 0; i < 5; i++) doReq(nvsram_host_pkg::OP_WRITE, nvsram_host_pkg::SEQ_ADDR[i], 8'hC0 + i[7:0]);
      for (int i = 0; i < 5; i++) begin
         doReq(nvsram_host_pkg::OP_READ, nvsram_host_pkg::SEQ_ADDR[i], 8'h00);
         check(rd, 8'hC0 + i[7:0]);
      end
   endtask
   task automatic saveLoadTest;
      doReq(nvsram_host_pkg::OP_WRITE, 11'h070F, 8'h22);
      doReq(nvsram_host_pkg::OP_SAVE, 11'h0000, 8'h00);
      check(saveCnt, 1);
      doReq(nvsram_host_pkg::OP_WRITE, 11'h0000, 8'h33);
      doReq(nvsram_host_pkg::OP_WRITE, 11'h070F, 8'h44);
      doReq(nvsram_host_pkg::OP_LOAD, 11'h0000, 8'h00);
      check(loadCnt, 1);
      check(saveCnt, 1);
      doReq(nvsram_host_pkg::OP_READ, 11'h0000, 8'h00);
      check(rd, 8'hC0);
      doReq(nvsram_host_pkg::OP_READ, 11'h070F, 8'h00);
      check(rd, 8'h22);
      doReq(nvsram_host_pkg::OP_SAVE, 11'h0000, 8'h00);
      check(saveCnt, 2);
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      powerupTest();
      rwTest();
      saveLoadTest();
      give_verdict();
   end
   // generous ceiling: the whole sequence needs well under 20 us
   initial begin
      #200000;
      error_cnt++;
      give_verdict();
   end
endmodule // nvsram_save_load_sequencer_tb_top
